//--- lookup_buffer_model.sv
`timescale 1ns/1ps
module lookup_buffer_model (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Lookup request
    input  wire        lookup_req,
    input  wire [31:0] lookup_vaddr,
    input  wire [3:0]  delay,
    // Lookup answer
    output reg         lookup_done,
    output reg         lookup_hit,
    output reg  [31:0] lookup_paddr,
    output reg         lookup_cacheable
);
    reg [3:0]  cnt_ff;
    reg        busy_ff;
    reg [31:0] va_ff;
    always @(posedge clk) begin
        lookup_done <= 1'b0;
        lookup_hit <= ~lookup_hit;
        lookup_paddr <= ~lookup_paddr;
        lookup_cacheable <= ~lookup_cacheable;
        if (!rst_n) begin
            busy_ff <= 1'b0;
            lookup_hit <= 1'b0;
            lookup_paddr <= 32'h0000_0000;
            lookup_cacheable <= 1'b0;
        end else if (lookup_req) begin
            busy_ff <= 1'b1;
            cnt_ff <= delay;
            va_ff <= lookup_vaddr;
        end else if (busy_ff && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end else if (busy_ff) begin
            // Pages with address bit 12 set have no entry
            busy_ff <= 1'b0;
            lookup_done <= 1'b1;
            lookup_hit <= ~va_ff[12];
            lookup_paddr <= {8'h01, va_ff[23:0]};
            lookup_cacheable <= va_ff[11];
        end
    end
endmodule // lookup_buffer_model

//--- mmu_address_area_translate.v
// Contract
// - Fixed cached area: physical address is virtual address with bit 31 cleared, no lookup.
// - Fixed cached area caching and write policy follow the cache control register.
// - Fixed uncached area: clear bits 31..29, never cache.
// - Fixed areas bypass the buffer and never raise buffer exceptions.
// - Lower and upper paged areas translate by page; writes follow cache control policy.
// - User mode reaches only addresses below 2 GB; higher ones give address error.
// - Control area maps peripheral registers, uncached, outside the translation path.
// - Upper three physical address bits are ignored, so aliases hit one location.
// - Paged accesses search the buffer; a hit supplies physical address and page control.
// - A paged access with no entry raises a miss; the core re-executes afterwards.
// - Translation disabled: virtual address used directly, low 29 bits significant.
// - Cached addresses go to the cache array with top three bits zero.
// - A translation control bit selects single or multiple space compare mode.
// - An 8-bit address space tag lives in page entry high, set by software.
// - Translation registers take defined values on reset; software sets the rest.
// - Privilege bit 0 means user mode, 1 means privileged; decode depends on it.
// - Single space mode while privileged skips the address space tag compare.
`timescale 1ns/1ps
`include "mmu_map.vh"

module mmu_address_area_translate (
    // Clock, reset, enable
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ce,
    // Register bus
    input  wire [31:0] address,
    input  wire        read,
    input  wire        write,
    input  wire [3:0]  byteenable,
    input  wire [31:0] writedata,
    output wire        waitrequest,
    output reg  [31:0] readdata,
    // Core access request
    input  wire        req_valid,
    input  wire [31:0] req_vaddr,
    input  wire        req_write,
    input  wire        privilege_bit,
    output wire        req_ready,
    // Core access answer
    output reg         resp_valid,
    output reg  [31:0] resp_paddr,
    output reg  [31:0] resp_cache_addr,
    output reg         resp_cacheable,
    output reg         resp_write_through,
    output reg         resp_control_area,
    output reg         resp_miss,
    output reg         resp_addr_error,
    // Buffer lookup
    output reg         lookup_req,
    output reg  [31:0] lookup_vaddr,
    output reg  [7:0]  lookup_tag,
    output reg         lookup_skip_tag,
    output reg         lookup_index_xor,
    input  wire        lookup_done,
    input  wire        lookup_hit,
    input  wire [31:0] lookup_paddr,
    input  wire        lookup_cacheable,
    // Interrupt
    output wire        irq
);

    localparam ST_IDLE   = 2'd0;
    localparam ST_LOOKUP = 2'd1;
    localparam ST_ANSWER = 2'd2;

    reg [1:0]  state_ff;
    reg [1:0]  nxt_state;
    reg [31:0] translation_control_ff;
    reg [31:0] page_entry_high_ff;
    reg [31:0] page_entry_low_ff;
    reg [31:0] table_base_ff;
    reg [31:0] fault_address_ff;
    reg [31:0] cache_control_reg_ff;
    reg [`IRQ_WIDTH-1:0] irq_status_ff;
    reg [`IRQ_WIDTH-1:0] irq_mask_ff;
    reg        bus_ack_ff;
    reg [31:0] vaddr_ff;
    reg        wr_ff;
    reg        priv_ff;

    // Apply byte enables to a register write
    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  be;
        input [31:0] wmask;
        integer i;
        begin
            merge_bytes = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
            merge_bytes = (merge_bytes & wmask) | (old_val & ~wmask);
        end
    endfunction

    // Drop the shadow bits of a physical address
    function [31:0] shadow;
        input [31:0] pa;
        begin
            shadow = pa & `PHYS_SHADOW_MASK;
        end
    endfunction

    wire bus_req   = read | write;
    wire bus_fire  = bus_req & bus_ack_ff;
    wire wr_fire   = write & bus_fire;
    wire rd_fire   = read & bus_fire;
    assign waitrequest = bus_req & ~bus_ack_ff;

    wire tc_enable  = translation_control_ff[`TC_ENABLE_BIT];
    wire tc_single  = translation_control_ff[`TC_SINGLE_SPACE_BIT];
    wire cc_on      = cache_control_reg_ff[`CC_CACHE_ON_BIT];
    wire cc_wt      = cache_control_reg_ff[`CC_WRITE_THROUGH_BIT];

    // Area decode of the held request
    wire [2:0] area      = vaddr_ff[31:29];
    wire       is_user_hi = ~priv_ff & vaddr_ff[31];
    wire       is_fixed_cached   = priv_ff & (area == `AREA_FIXED_CACHED_CODE);
    wire       is_fixed_uncached = priv_ff & (area == `AREA_FIXED_UNCACHED_CODE);
    wire       is_control        = priv_ff & (area == `AREA_CONTROL_CODE);

    assign req_ready = (state_ff == ST_IDLE);

    reg        nxt_resp_valid;
    reg [31:0] nxt_paddr;
    reg        nxt_cacheable;
    reg        nxt_miss;
    reg        nxt_addr_error;
    reg        nxt_control;
    reg        nxt_lookup_req;

    always @* begin
        nxt_state      = state_ff;
        nxt_resp_valid = 1'b0;
        nxt_paddr      = 32'h0000_0000;
        nxt_cacheable  = 1'b0;
        nxt_miss       = 1'b0;
        nxt_addr_error = 1'b0;
        nxt_control    = 1'b0;
        nxt_lookup_req = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_state = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                nxt_resp_valid = 1'b1;
                nxt_state      = ST_IDLE;
                if (is_user_hi) begin
                    nxt_addr_error = 1'b1;
                end else if (is_control) begin
                    nxt_control = 1'b1;
                    nxt_paddr   = vaddr_ff;
                end else if (is_fixed_cached) begin
                    nxt_paddr     = shadow(vaddr_ff & `FIXED_CACHED_MASK);
                    nxt_cacheable = cc_on;
                end else if (is_fixed_uncached) begin
                    nxt_paddr     = shadow(vaddr_ff);
                end else if (~tc_enable) begin
                    nxt_paddr     = shadow(vaddr_ff);
                    nxt_cacheable = cc_on;
                end else begin
                    nxt_resp_valid = 1'b0;
                    nxt_lookup_req = 1'b1;
                    nxt_state      = ST_LOOKUP;
                end
            end
            ST_LOOKUP: begin
                if (lookup_done) begin
                    nxt_resp_valid = 1'b1;
                    nxt_state      = ST_IDLE;
                    if (lookup_hit) begin
                        nxt_paddr     = shadow(lookup_paddr);
                        nxt_cacheable = cc_on & lookup_cacheable;
                    end else begin
                        nxt_miss = 1'b1;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Access path state
    always @(posedge clk) begin
        if (!rst_n) begin
            state_ff           <= ST_IDLE;
            vaddr_ff           <= 32'h0000_0000;
            wr_ff              <= 1'b0;
            priv_ff            <= 1'b1;
            resp_valid         <= 1'b0;
            resp_paddr         <= 32'h0000_0000;
            resp_cache_addr    <= 32'h0000_0000;
            resp_cacheable     <= 1'b0;
            resp_write_through <= 1'b0;
            resp_control_area  <= 1'b0;
            resp_miss          <= 1'b0;
            resp_addr_error    <= 1'b0;
            lookup_req         <= 1'b0;
            lookup_vaddr       <= 32'h0000_0000;
            lookup_tag         <= 8'h00;
            lookup_skip_tag    <= 1'b0;
            lookup_index_xor   <= 1'b0;
        end else if (ce) begin
            state_ff           <= nxt_state;
            if (state_ff == ST_IDLE && req_valid) begin
                vaddr_ff <= req_vaddr;
                wr_ff    <= req_write;
                priv_ff  <= privilege_bit;
            end
            resp_valid         <= nxt_resp_valid;
            resp_paddr         <= nxt_paddr;
            resp_cache_addr    <= shadow(nxt_paddr);
            resp_cacheable     <= nxt_cacheable;
            resp_write_through <= nxt_cacheable & wr_ff & cc_wt;
            resp_control_area  <= nxt_control;
            resp_miss          <= nxt_miss;
            resp_addr_error    <= nxt_addr_error;
            lookup_req         <= nxt_lookup_req;
            if (nxt_lookup_req) begin
                lookup_vaddr     <= vaddr_ff;
                lookup_tag       <= page_entry_high_ff[`PEH_TAG_MSB:`PEH_TAG_LSB];
                lookup_skip_tag  <= tc_single & priv_ff;
                lookup_index_xor <= translation_control_ff[`TC_INDEX_XOR_BIT];
            end
        end
    end

    wire fault_evt = nxt_resp_valid & (nxt_miss | nxt_addr_error);
    wire [`IRQ_WIDTH-1:0] irq_evt = {nxt_addr_error & nxt_resp_valid,
                                     nxt_miss & nxt_resp_valid};

    // Register file
    always @(posedge clk) begin
        if (!rst_n) begin
            bus_ack_ff             <= 1'b0;
            translation_control_ff <= `RST_TRANSLATION_CONTROL;
            page_entry_high_ff     <= `RST_PAGE_ENTRY_HIGH;
            page_entry_low_ff      <= `RST_PAGE_ENTRY_LOW;
            table_base_ff          <= `RST_TABLE_BASE;
            fault_address_ff       <= `RST_FAULT_ADDRESS;
            cache_control_reg_ff   <= `RST_CACHE_CONTROL;
            irq_status_ff          <= {`IRQ_WIDTH{1'b0}};
            irq_mask_ff            <= {`IRQ_WIDTH{1'b0}};
            readdata               <= 32'h0000_0000;
        end else if (ce) begin
            bus_ack_ff <= bus_req & ~bus_ack_ff;
            if (wr_fire) begin
                case (address)
                    `ADDR_TRANSLATION_CONTROL: begin
                        translation_control_ff <= merge_bytes(translation_control_ff,
                            writedata, byteenable, `TC_WRITE_MASK);
                    end
                    `ADDR_PAGE_ENTRY_HIGH: begin
                        page_entry_high_ff <= merge_bytes(page_entry_high_ff,
                            writedata, byteenable, `PEH_WRITE_MASK);
                    end
                    `ADDR_PAGE_ENTRY_LOW: begin
                        page_entry_low_ff <= merge_bytes(page_entry_low_ff,
                            writedata, byteenable, 32'hFFFF_FFFF);
                    end
                    `ADDR_TABLE_BASE: begin
                        table_base_ff <= merge_bytes(table_base_ff,
                            writedata, byteenable, 32'hFFFF_FFFF);
                    end
                    `ADDR_FAULT_ADDRESS: begin
                        fault_address_ff <= merge_bytes(fault_address_ff,
                            writedata, byteenable, 32'hFFFF_FFFF);
                    end
                    `ADDR_CACHE_CONTROL: begin
                        cache_control_reg_ff <= merge_bytes(cache_control_reg_ff,
                            writedata, byteenable, `CC_WRITE_MASK);
                    end
                    `ADDR_IRQ_MASK: begin
                        if (byteenable[0]) begin
                            irq_mask_ff <= writedata[`IRQ_WIDTH-1:0];
                        end
                    end
                    default: begin
                        irq_mask_ff <= irq_mask_ff;
                    end
                endcase
            end
            // Hardware fault capture wins over a same-cycle software write
            if (fault_evt) begin
                fault_address_ff   <= vaddr_ff;
                page_entry_high_ff <= (vaddr_ff & `PEH_VPN_MASK) |
                                      (page_entry_high_ff & ~`PEH_VPN_MASK);
            end
            // Read clears status; a new event in the same cycle stays set
            if (rd_fire && address == `ADDR_IRQ_STATUS) begin
                irq_status_ff <= irq_evt;
            end else begin
                irq_status_ff <= irq_status_ff | irq_evt;
            end
            if (bus_req & ~bus_ack_ff) begin
                case (address)
                    `ADDR_TRANSLATION_CONTROL: readdata <= translation_control_ff;
                    `ADDR_PAGE_ENTRY_HIGH:     readdata <= page_entry_high_ff;
                    `ADDR_PAGE_ENTRY_LOW:      readdata <= page_entry_low_ff;
                    `ADDR_TABLE_BASE:          readdata <= table_base_ff;
                    `ADDR_FAULT_ADDRESS:       readdata <= fault_address_ff;
                    `ADDR_CACHE_CONTROL:       readdata <= cache_control_reg_ff;
                    `ADDR_IRQ_STATUS:          readdata <= {30'h0000_0000, irq_status_ff};
                    `ADDR_IRQ_MASK:            readdata <= {30'h0000_0000, irq_mask_ff};
                    default:                   readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign irq = |(irq_status_ff & irq_mask_ff);

endmodule // mmu_address_area_translate

//--- mmu_address_area_translate_bench.sv
`timescale 1ns/1ps
`include "mmu_map.vh"
module mmu_address_area_translate_bench;
    reg         clk, rst_n, ce, read, write, req_valid, req_write, privilege_bit;
    reg  [31:0] address, writedata, req_vaddr;
    reg  [3:0]  byteenable, delay;
    wire        waitrequest, req_ready, resp_valid, resp_cacheable, resp_write_through;
    wire        resp_control_area, resp_miss, resp_addr_error, lookup_req, lookup_skip_tag;
    wire        lookup_done, lookup_hit, lookup_cacheable, irq, lookup_index_xor;
    wire [31:0] readdata, resp_paddr, resp_cache_addr, lookup_vaddr, lookup_paddr;
    wire [7:0]  lookup_tag;
    integer     errors, check_count, n;
    reg  [31:0] rd;
    mmu_address_area_translate mmu_address_area_translate_i (.clk, .rst_n, .ce, .address, .read,
        .write, .byteenable, .writedata, .waitrequest, .readdata, .req_valid, .req_vaddr,
        .req_write, .privilege_bit, .req_ready, .resp_valid, .resp_paddr, .resp_cache_addr,
        .resp_cacheable, .resp_write_through, .resp_control_area, .resp_miss, .resp_addr_error,
        .lookup_req, .lookup_vaddr, .lookup_tag, .lookup_skip_tag, .lookup_index_xor,
        .lookup_done, .lookup_hit, .lookup_paddr, .lookup_cacheable, .irq);
    lookup_buffer_model lookup_buffer_model_i (.clk, .rst_n, .lookup_req, .lookup_vaddr,
        .delay, .lookup_done, .lookup_hit, .lookup_paddr, .lookup_cacheable);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task check(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [31:0] a, input [31:0] d);
        begin
            @(posedge clk);
            address <= a;
            writedata <= d;
            write <= w;
            read <= ~w;
            @(posedge clk);
            while (waitrequest !== 1'b0) @(posedge clk);
            rd = readdata;
            write <= 1'b0;
            read <= 1'b0;
        end
    endtask
    task rd_chk(input [31:0] a, input [31:0] exp);
        begin
            bus(1'b0, a, 32'h0000_0000);
            check(rd, exp);
        end
    endtask
    // Flags: cacheable, write_through, control_area, miss, addr_error
    task access(input [31:0] va, input p, input w, input [31:0] pa, input [4:0] f);
        begin
            @(posedge clk);
            req_vaddr <= va;
            privilege_bit <= p;
            req_write <= w;
            req_valid <= 1'b1;
            @(posedge clk);
            while (req_ready !== 1'b1) @(posedge clk);
            req_valid <= 1'b0;
            n = 0;
            @(posedge clk);
            while (resp_valid !== 1'b1 && n < 40) begin
                @(posedge clk);
                n = n + 1;
            end
            check({resp_valid, resp_cacheable, resp_write_through, resp_control_area,
                resp_miss, resp_addr_error}, {1'b1, f});
            check(resp_paddr, pa);
            if (!f[2]) check(resp_cache_addr, pa);
        end
    endtask
    task summarize;
        begin
            $display("checks=%0d errors=%0d", check_count, errors);
            if (errors == 0 && check_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors = errors + 1;
        summarize;
    end
    initial begin
        errors = 0;
        check_count = 0;
        {rst_n, read, write, req_valid, req_write, privilege_bit} = 6'h00;
        {address, writedata, req_vaddr, delay} = 100'h0;
        ce = 1'b1;
        byteenable = 4'hF;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`ADDR_TRANSLATION_CONTROL, `RST_TRANSLATION_CONTROL);
        rd_chk(`ADDR_PAGE_ENTRY_HIGH, `RST_PAGE_ENTRY_HIGH);
        rd_chk(`ADDR_PAGE_ENTRY_LOW, `RST_PAGE_ENTRY_LOW);
        rd_chk(`ADDR_TABLE_BASE, `RST_TABLE_BASE);
        rd_chk(`ADDR_FAULT_ADDRESS, `RST_FAULT_ADDRESS);
        bus(1'b1, `ADDR_TRANSLATION_CONTROL, 32'hFFFF_FFFF);
        rd_chk(`ADDR_TRANSLATION_CONTROL, 32'h0000_0103);
        bus(1'b1, `ADDR_PAGE_ENTRY_HIGH, 32'hFFFF_FFFF);
        rd_chk(`ADDR_PAGE_ENTRY_HIGH, 32'hFFFF_FCFF);
        bus(1'b1, `ADDR_TABLE_BASE, 32'h1234_5678);
        rd_chk(`ADDR_TABLE_BASE, 32'h1234_5678);
        bus(1'b1, 32'h0FFF_FF00, 32'hFFFF_FFFF);
        rd_chk(32'h0FFF_FF00, 32'h0000_0000);
        $display("registers test done");
        bus(1'b1, `ADDR_TRANSLATION_CONTROL, 32'h0000_0000);
        bus(1'b1, `ADDR_CACHE_CONTROL, 32'h0000_0003);
        access(32'h8000_1000, 1'b1, 1'b1, 32'h0000_1000, 5'b11000);
        access(32'hA000_1000, 1'b1, 1'b1, 32'h0000_1000, 5'b00000);
        access(32'hE000_0010, 1'b1, 1'b0, 32'hE000_0010, 5'b00100);
        access(32'hC000_1000, 1'b1, 1'b1, 32'h0000_1000, 5'b11000);
        access(32'h0000_1000, 1'b0, 1'b0, 32'h0000_1000, 5'b10000);
        access(32'h8000_0000, 1'b0, 1'b0, 32'h0000_0000, 5'b00001);
        check(irq, 1'b0);
        rd_chk(`ADDR_FAULT_ADDRESS, 32'h8000_0000);
        rd_chk(`ADDR_IRQ_STATUS, 32'h0000_0002);
        rd_chk(`ADDR_IRQ_STATUS, 32'h0000_0000);
        bus(1'b1, `ADDR_CACHE_CONTROL, 32'h0000_0002);
        access(32'h8000_1000, 1'b1, 1'b1, 32'h0000_1000, 5'b00000);
        $display("fixed and disabled test done");
        bus(1'b1, `ADDR_TRANSLATION_CONTROL, 32'h0000_0103);
        bus(1'b1, `ADDR_PAGE_ENTRY_HIGH, 32'h0000_005A);
        bus(1'b1, `ADDR_IRQ_MASK, 32'h0000_0003);
        bus(1'b1, `ADDR_CACHE_CONTROL, 32'h0000_0001);
        access(32'h0000_2800, 1'b0, 1'b1, 32'h0100_2800, 5'b10000);
        check(lookup_tag, 8'h5A);
        check(lookup_vaddr, 32'h0000_2800);
        check(lookup_index_xor, 1'b1);
        check(lookup_skip_tag, 1'b0);
        delay <= 4'h5;
        access(32'hC000_2000, 1'b1, 1'b0, 32'h0100_2000, 5'b00000);
        check(lookup_skip_tag, 1'b1);
        access(32'h0000_3000, 1'b0, 1'b0, 32'h0000_0000, 5'b00010);
        @(negedge clk);
        check(irq, 1'b1);
        rd_chk(`ADDR_FAULT_ADDRESS, 32'h0000_3000);
        rd_chk(`ADDR_PAGE_ENTRY_HIGH, 32'h0000_305A);
        rd_chk(`ADDR_IRQ_STATUS, 32'h0000_0001);
        @(negedge clk);
        check(irq, 1'b0);
        access(32'h8000_1000, 1'b1, 1'b0, 32'h0000_1000, 5'b10000);
        $display("paged test done");
        summarize;
    end
endmodule // mmu_address_area_translate_bench

//--- mmu_address_area_translate_monitor.sv
`timescale 1ns/1ps
module mmu_area_monitor (
    // Clock and reset
    input wire        clk,
    input wire        rst_n,
    // Core side
    input wire        req_valid,
    input wire [31:0] req_vaddr,
    input wire        privilege_bit,
    input wire        req_ready,
    input wire        resp_valid,
    input wire [31:0] resp_paddr,
    input wire [31:0] resp_cache_addr,
    input wire        resp_cacheable,
    input wire        resp_control_area,
    input wire        resp_miss,
    input wire        resp_addr_error,
    // Buffer side
    input wire        lookup_req,
    input wire        lookup_done,
    input wire        lookup_hit,
    input wire [31:0] lookup_paddr
);
    reg  [31:0] va_ff;
    reg         pv_ff;
    wire        take = req_valid && req_ready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Remember the request being answered
    always @(posedge clk) begin
        if (!rst_n) begin
            va_ff <= 32'h0000_0000;
            pv_ff <= 1'b0;
        end else if (take) begin
            va_ff <= req_vaddr;
            pv_ff <= privilege_bit;
        end
    end
    property p_fixed_cached;
        resp_valid && pv_ff && va_ff[31:29] == 3'h4 |-> resp_paddr == {3'b000, va_ff[28:0]};
    endproperty
    a_fixed_cached: assert property (p_fixed_cached) else $error("fixed cached address wrong");
    property p_fixed_uncached;
        resp_valid && pv_ff && va_ff[31:29] == 3'h5
            |-> resp_paddr == {3'b000, va_ff[28:0]} && !resp_cacheable;
    endproperty
    a_fixed_uncached: assert property (p_fixed_uncached) else $error("uncached area wrong");
    property p_no_lookup;
        take && privilege_bit && req_vaddr[31:30] == 2'b10 |-> ##1 (!lookup_req && !resp_miss)[*2];
    endproperty
    a_no_lookup: assert property (p_no_lookup) else $error("fixed area used buffer");
    property p_user_error;
        take && !privilege_bit && req_vaddr[31] |-> ##2 resp_valid && resp_addr_error;
    endproperty
    a_user_error: assert property (p_user_error) else $error("user high address allowed");
    property p_control;
        resp_valid && pv_ff && va_ff[31:29] == 3'h7 |-> resp_control_area && !resp_cacheable;
    endproperty
    a_control: assert property (p_control) else $error("control area wrong");
    property p_shadow;
        resp_valid && !resp_control_area |-> resp_paddr[31:29] == 3'b000;
    endproperty
    a_shadow: assert property (p_shadow) else $error("top address bits not zero");
    property p_cache_addr;
        resp_valid && resp_cacheable |-> resp_cache_addr == {3'b000, resp_paddr[28:0]};
    endproperty
    a_cache_addr: assert property (p_cache_addr) else $error("cache address wrong");
    property p_hit;
        lookup_done && lookup_hit |=> resp_valid && !resp_miss
            && resp_paddr == ($past(lookup_paddr) & 32'h1FFF_FFFF);
    endproperty
    a_hit: assert property (p_hit) else $error("hit answer wrong");
    property p_miss;
        lookup_done && !lookup_hit |=> resp_valid && resp_miss && resp_paddr == 32'h0000_0000;
    endproperty
    a_miss: assert property (p_miss) else $error("miss not raised");
endmodule // mmu_area_monitor
bind mmu_address_area_translate mmu_area_monitor mmu_area_monitor_i (.clk, .rst_n, .req_valid,
    .req_vaddr, .privilege_bit, .req_ready, .resp_valid, .resp_paddr, .resp_cache_addr,
    .resp_cacheable, .resp_control_area, .resp_miss, .resp_addr_error, .lookup_req,
    .lookup_done, .lookup_hit, .lookup_paddr);

//--- mmu_map.vh
`ifndef MMU_MAP_VH
`define MMU_MAP_VH

// Register byte addresses
`define ADDR_TRANSLATION_CONTROL 32'h0FFF_FFE0
`define ADDR_PAGE_ENTRY_HIGH     32'h0FFF_FFF0
`define ADDR_PAGE_ENTRY_LOW      32'hFFFF_FFF4
`define ADDR_TABLE_BASE          32'h0FFF_FFF8
`define ADDR_FAULT_ADDRESS       32'h0FFF_FFFC
`define ADDR_CACHE_CONTROL       32'h0FFF_FFE4
`define ADDR_IRQ_STATUS          32'h0FFF_FFE8
`define ADDR_IRQ_MASK            32'h0FFF_FFEC

// Reset values
`define RST_TRANSLATION_CONTROL  32'h0000_0000
`define RST_PAGE_ENTRY_HIGH      32'h0000_0000
`define RST_PAGE_ENTRY_LOW       32'h0000_0000
`define RST_TABLE_BASE           32'h0000_0000
`define RST_FAULT_ADDRESS        32'h0000_0000
`define RST_CACHE_CONTROL        32'h0000_0000

// Translation control fields
`define TC_ENABLE_BIT            0
`define TC_INDEX_XOR_BIT         1
`define TC_SINGLE_SPACE_BIT      8
`define TC_WRITE_MASK            32'h0000_0103

// Cache control fields
`define CC_CACHE_ON_BIT          0
`define CC_WRITE_THROUGH_BIT     1
`define CC_WRITE_MASK            32'h0000_0003

// Page entry high fields
`define PEH_TAG_LSB              0
`define PEH_TAG_MSB              7
`define PEH_VPN_MASK             32'hFFFF_FC00
`define PEH_WRITE_MASK           32'hFFFF_FCFF

// Interrupt status bits
`define IRQ_MISS_BIT             0
`define IRQ_ADDR_ERR_BIT         1
`define IRQ_WIDTH                2

// Area codes taken from virtual address bits 31..29
`define AREA_FIXED_CACHED_CODE   3'h4
`define AREA_FIXED_UNCACHED_CODE 3'h5
`define AREA_UPPER_PAGED_CODE    3'h6
`define AREA_CONTROL_CODE        3'h7

// Physical address significant bits
`define PHYS_SHADOW_MASK         32'h1FFF_FFFF
`define FIXED_CACHED_MASK        32'h7FFF_FFFF

`endif
